// file: sccm_clock_modes.sv
// per-channel clock mode selection, strobes, gating and slot control
// Operation
// - mode 0: rx pin clock, tx pin or generator
// - 0b drives tx pin only when enabled
// - mode 1: rx pin clocks both, strobes
// - one strobe permits a whole byte/character
// - mode 2: generator from rx pin, loop
// - 2a tx pin, 2b generator/16 output
// - mode 3: loop or generator drives both
// - mode 4: separate clocks, low gating honoured
// - mode 4 routes tx clock to rts
// - mode 5: rx pin clock, slot strobes
// - one slot of 1 to 512 bits
// - up to 32 masked 8-bit slots
// - independent positions, delay 1 to 1024
// - mode 5 tx pin low in tx slot
// - delay is 1 + number*8 + shift
// - masks enabled force 8-bit width
// - tx and rx fields from own registers
// - mode 6 like 2, crystal feeds generator
// - mode field plus source select bit
// - loop receive clock is reference/16
`timescale 1ns/100ps
module sccm_clock_modes
  import sccm_pkg::*;
#(
  parameter int RATE_CNT_W = 21
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_clock_pin,
  input wire logic tx_clock_pin_i,
  output logic tx_clock_pin_o,
  output logic tx_clock_pin_oe,
  input wire logic crystal_input,
  input wire logic carrier_detect_pin,
  input wire logic rx_gate_n,
  input wire logic tx_gate_n,
  input wire logic frame_sync_pin,
  output logic rts_clock_o,
  output logic rts_clock_route,
  output logic osc_enable,
  output logic rx_bit_en,
  output logic tx_bit_en
);

  // largest divider is 64 * 2^15, so the counter needs 21 bits
  if (RATE_CNT_W < 21) begin : g_bad
    $error("sccm_clock_modes: RATE_CNT_W must be at least 21");
  end

  // pin indices in the synchroniser vector
  localparam int P_RXC = 0;
  localparam int P_TXC = 1;
  localparam int P_XTL = 2;
  localparam int P_CD = 3;
  localparam int P_RG = 4;
  localparam int P_TG = 5;
  localparam int P_FS = 6;

  logic [31:0] cfg_reg;       // channel_config_0
  logic [31:0] rate_reg;      // rate generator divider
  logic [31:0] tx_slot_assign_reg;
  logic [31:0] rx_slot_assign_reg;
  logic [31:0] tx_pcm_mask;
  logic [31:0] rx_pcm_mask;
  logic [31:0] prdata_reg;    // read data caught in setup phase

  logic [6:0] pin_raw;        // asynchronous pins
  logic [6:0] sync1_reg;      // first stage, read only by sync2
  logic [6:0] sync2_reg;      // usable level
  logic [6:0] sync3_reg;      // previous level for edge detect
  logic [6:0] rise;           // one-cycle rising edge

  sccm_mode_t mode;
  logic ssel;
  logic byte_align;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic cfg_wr;

  logic [RATE_CNT_W-1:0] rg_cnt_reg;  // rate generator counter
  logic [RATE_CNT_W-1:0] rg_k;        // division factor
  logic rg_src;                       // generator input edge
  logic rg_used;
  logic rg_tick;
  logic rg_lvl;                       // generator output as a level
  logic [3:0] div16_reg;              // loop / divide-by-16 counter
  logic div16_tick;

  logic [2:0] rx_run_reg;             // bits left in aligned byte
  logic [2:0] tx_run_reg;
  logic rx_raw;
  logic tx_raw;
  logic rx_permit;
  logic tx_permit;
  logic tx_lvl;
  logic tx_oe_next;

  sccm_slot_if rx_if ();
  sccm_slot_if tx_if ();

  // decoded configuration; mode plus source select pick the variant
  assign mode = sccm_mode_t'(cfg_reg[CFG_MODE_LSB +: 3]);
  assign ssel = cfg_reg[CFG_SSEL];
  assign byte_align = cfg_reg[CFG_BYTE_ALIGN];

  // apb decode, zero wait states
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CFG) || (a == ADDR_RATE) || (a == ADDR_TX_SLOT) ||
             (a == ADDR_RX_SLOT) || (a == ADDR_TX_MASK) || (a == ADDR_RX_MASK) ||
             (a == ADDR_STATUS);
  endfunction

  assign addr_ok = mapped(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign cfg_wr = wr_en && (paddr == ADDR_CFG);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_reg;

  // register writes; status is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
      rate_reg <= RATE_RESET;
      tx_slot_assign_reg <= SLOT_RESET;
      rx_slot_assign_reg <= SLOT_RESET;
      tx_pcm_mask <= MASK_RESET;
      rx_pcm_mask <= MASK_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CFG: begin
          cfg_reg <= {22'h000000, pwdata[9:4], 1'b0, pwdata[2:0]};
        end
        ADDR_RATE: begin
          rate_reg <= {20'h00000, pwdata[11:8], 2'b00, pwdata[5:0]};
        end
        ADDR_TX_SLOT: begin
          tx_slot_assign_reg <= {7'h00, pwdata[24:16], 5'h00, pwdata[10:8], 1'b0, pwdata[6:0]};
        end
        ADDR_RX_SLOT: begin
          rx_slot_assign_reg <= {7'h00, pwdata[24:16], 5'h00, pwdata[10:8], 1'b0, pwdata[6:0]};
        end
        ADDR_TX_MASK: begin
          tx_pcm_mask <= pwdata;
        end
        ADDR_RX_MASK: begin
          rx_pcm_mask <= pwdata;
        end
        default: begin
          cfg_reg <= cfg_reg;
        end
      endcase
    end
  end

  // read mux, sampled in the setup phase so data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        ADDR_CFG: prdata_reg <= cfg_reg;
        ADDR_RATE: prdata_reg <= rate_reg;
        ADDR_TX_SLOT: prdata_reg <= tx_slot_assign_reg;
        ADDR_RX_SLOT: prdata_reg <= rx_slot_assign_reg;
        ADDR_TX_MASK: prdata_reg <= tx_pcm_mask;
        ADDR_RX_MASK: prdata_reg <= rx_pcm_mask;
        ADDR_STATUS: begin
          prdata_reg <= {17'h00000, sync2_reg[P_FS], sync2_reg[P_RXC], tx_run_reg != 3'h0,
                         rx_run_reg != 3'h0, osc_enable, tx_if.window, rx_if.window,
                         3'h0, ssel, 1'b0, mode};
        end
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // every pin crosses two flops before any logic sees it
  assign pin_raw = {frame_sync_pin, tx_gate_n, rx_gate_n, carrier_detect_pin,
                    crystal_input, tx_clock_pin_i, rx_clock_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      sync3_reg <= 7'h00;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~sync3_reg;

  // generator input: crystal in 0b/6/7, receive clock pin in 2/3
  always_comb begin
    rg_src = rise[P_RXC];
    rg_used = 1'b1;
    case (mode)
      SCCM_MODE_0: begin
        rg_src = rise[P_XTL];
        rg_used = ssel;
      end
      SCCM_MODE_6, SCCM_MODE_7: begin
        rg_src = rise[P_XTL];
      end
      SCCM_MODE_2, SCCM_MODE_3: begin
        rg_src = rise[P_RXC];
      end
      default: begin
        rg_used = 1'b0;
      end
    endcase
  end

  // divider k = (n+1) * 2^m on generator source edges
  assign rg_k = (RATE_CNT_W'(rate_reg[RATE_N_LSB +: 6]) + RATE_CNT_W'(1)) <<
                rate_reg[RATE_M_LSB +: 4];
  assign rg_tick = rg_used && rg_src && (rg_cnt_reg >= rg_k - RATE_CNT_W'(1));
  // level is high in the second half of each period; k of 1 stays high
  assign rg_lvl = rg_cnt_reg >= (rg_k >> 1);

  // restarting counters on a config write avoids a short first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rg_cnt_reg <= '0;
    end else if (cfg_wr || !rg_used) begin
      rg_cnt_reg <= '0;
    end else if (rg_tick) begin
      rg_cnt_reg <= '0;
    end else if (rg_src) begin
      rg_cnt_reg <= rg_cnt_reg + RATE_CNT_W'(1);
    end
  end

  // reference/16: recovered receive clock and divided transmit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div16_reg <= 4'h0;
    end else if (cfg_wr) begin
      div16_reg <= 4'h0;
    end else if (rg_tick) begin
      div16_reg <= div16_reg + 4'h1;
    end
  end

  assign div16_tick = rg_tick && (div16_reg == REF_DIV_LAST);

  // byte/character alignment: one strobe opens eight bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_run_reg <= 3'h0;
    end else if (cfg_wr) begin
      rx_run_reg <= 3'h0;
    end else if (rx_raw && mode == SCCM_MODE_1 && byte_align) begin
      if (rx_run_reg != 3'h0) begin
        rx_run_reg <= rx_run_reg - 3'h1;
      end else if (sync2_reg[P_CD]) begin
        rx_run_reg <= CHAR_BITS_LAST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_run_reg <= 3'h0;
    end else if (cfg_wr) begin
      tx_run_reg <= 3'h0;
    end else if (tx_raw && mode == SCCM_MODE_1 && byte_align) begin
      if (tx_run_reg != 3'h0) begin
        tx_run_reg <= tx_run_reg - 3'h1;
      end else if (sync2_reg[P_TXC]) begin
        tx_run_reg <= CHAR_BITS_LAST;
      end
    end
  end

  // per-mode clock source and permission selection
  always_comb begin
    rx_raw = rise[P_RXC];
    tx_raw = rise[P_TXC];
    rx_permit = 1'b1;
    tx_permit = 1'b1;
    case (mode)
      SCCM_MODE_0: begin
        rx_raw = rise[P_RXC];
        tx_raw = ssel ? rg_tick : rise[P_TXC];
      end
      SCCM_MODE_1: begin
        rx_raw = rise[P_RXC];
        tx_raw = rise[P_RXC];
        rx_permit = sync2_reg[P_CD] || (byte_align && rx_run_reg != 3'h0);
        tx_permit = sync2_reg[P_TXC] || (byte_align && tx_run_reg != 3'h0);
      end
      SCCM_MODE_2, SCCM_MODE_6: begin
        rx_raw = div16_tick;
        tx_raw = ssel ? div16_tick : rise[P_TXC];
      end
      SCCM_MODE_3, SCCM_MODE_7: begin
        rx_raw = ssel ? rg_tick : div16_tick;
        tx_raw = ssel ? rg_tick : div16_tick;
      end
      SCCM_MODE_4: begin
        rx_raw = rise[P_RXC];
        tx_raw = rise[P_TXC];
        rx_permit = !sync2_reg[P_RG];
        tx_permit = !sync2_reg[P_TG];
      end
      SCCM_MODE_5: begin
        rx_raw = rise[P_RXC];
        tx_raw = rise[P_RXC];
        rx_permit = rx_if.window;
        tx_permit = tx_if.window;
      end
      default: begin
        rx_permit = 1'b0;
        tx_permit = 1'b0;
      end
    endcase
  end

  // single-cycle enables: no partial clock can appear on a switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit_en <= 1'b0;
      tx_bit_en <= 1'b0;
    end else begin
      rx_bit_en <= rx_raw && rx_permit && !cfg_wr;
      tx_bit_en <= tx_raw && tx_permit && !cfg_wr;
    end
  end

  // slot assigners share the receive pin clock and frame sync
  assign rx_if.bit_tick = (mode == SCCM_MODE_5) && rise[P_RXC];
  assign tx_if.bit_tick = (mode == SCCM_MODE_5) && rise[P_RXC];
  assign rx_if.frame_start = rise[P_FS];
  assign tx_if.frame_start = rise[P_FS];
  assign rx_if.slot_num = rx_slot_assign_reg[SLOT_NUM_LSB +: 7];
  assign rx_if.clk_shift = rx_slot_assign_reg[SLOT_SHIFT_LSB +: 3];
  assign rx_if.width_m1 = rx_slot_assign_reg[SLOT_WIDTH_LSB +: 9];
  assign tx_if.slot_num = tx_slot_assign_reg[SLOT_NUM_LSB +: 7];
  assign tx_if.clk_shift = tx_slot_assign_reg[SLOT_SHIFT_LSB +: 3];
  assign tx_if.width_m1 = tx_slot_assign_reg[SLOT_WIDTH_LSB +: 9];
  assign rx_if.mask = rx_pcm_mask;
  assign tx_if.mask = tx_pcm_mask;
  assign rx_if.mask_en = cfg_reg[CFG_PCM_MASK_EN];
  assign tx_if.mask_en = cfg_reg[CFG_PCM_MASK_EN];

  sccm_slot #(
    .SLOT_COUNT(32)
  ) u_rx_slot (
    .pclk(pclk),
    .presetn(presetn),
    .s(rx_if.slot_assigner)
  );

  sccm_slot #(
    .SLOT_COUNT(32)
  ) u_tx_slot (
    .pclk(pclk),
    .presetn(presetn),
    .s(tx_if.slot_assigner)
  );

  // transmit clock pin: monitor of generated clock or slot status
  always_comb begin
    tx_lvl = 1'b1;
    tx_oe_next = 1'b0;
    case (mode)
      SCCM_MODE_0: begin
        tx_lvl = rg_lvl;
        tx_oe_next = ssel;
      end
      SCCM_MODE_2, SCCM_MODE_6: begin
        tx_lvl = div16_reg[3];
        tx_oe_next = ssel;
      end
      SCCM_MODE_3, SCCM_MODE_7: begin
        tx_lvl = ssel ? rg_lvl : div16_reg[3];
        tx_oe_next = 1'b1;
      end
      SCCM_MODE_5: begin
        tx_lvl = !tx_if.window;
        tx_oe_next = 1'b1;
      end
      default: begin
        tx_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clock_pin_o <= 1'b1;
      tx_clock_pin_oe <= 1'b0;
    end else begin
      tx_clock_pin_o <= tx_lvl;
      tx_clock_pin_oe <= tx_oe_next && cfg_reg[CFG_TOE];
    end
  end

  // rts carries the transmit clock from the edge stage plus one flop, so it rises one cycle after tx_bit_en
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_clock_o <= 1'b0;
      rts_clock_route <= 1'b0;
    end else begin
      rts_clock_o <= sync3_reg[P_TXC];
      rts_clock_route <= (mode == SCCM_MODE_4) && cfg_reg[CFG_TX_CLOCK_OUT_SELECT];
    end
  end

  // crystal oscillator runs only where a mode needs it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= (mode == SCCM_MODE_0 && ssel) || mode == SCCM_MODE_6 ||
                    mode == SCCM_MODE_7;
    end
  end

endmodule

// file: sccm_clock_modes_monitor.sv
// assertion checker watching the clock mode selector ports
`timescale 1ns/100ps
module sccm_clock_modes_monitor
  import sccm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_clock_pin,
  input wire logic tx_clock_pin_i,
  input wire logic tx_clock_pin_o,
  input wire logic tx_clock_pin_oe,
  input wire logic rx_gate_n,
  input wire logic tx_gate_n,
  input wire logic rts_clock_o,
  input wire logic rts_clock_route,
  input wire logic osc_enable,
  input wire logic rx_bit_en,
  input wire logic tx_bit_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] cfg_reg; // shadow of the config word
  logic [1:0] age_reg; // edges since config write, saturating
  logic [3:0] rxg_reg; // edges rx gate held high, stops at 8
  logic [3:0] txg_reg; // same for tx gate
  logic acc; // apb access phase
  logic mapped; // word address inside the map
  logic settled; // registered outputs had time to follow config
  assign acc = psel && penable;
  assign mapped = (paddr <= ADDR_STATUS) && (paddr[1:0] == 2'h0);
  assign settled = age_reg == 2'h3;
  // shadow config, since outputs lag the write by a couple of edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= 10'h000;
      age_reg <= 2'h0;
    end else if (acc && pwrite && paddr == ADDR_CFG) begin
      cfg_reg <= pwdata[9:0];
      age_reg <= 2'h0;
    end else if (!settled) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  // gate run lengths; long enough that sync delay is covered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxg_reg <= 4'h0;
      txg_reg <= 4'h0;
    end else begin
      rxg_reg <= rx_gate_n ? rxg_reg + {3'h0, rxg_reg != 4'h8} : 4'h0;
      txg_reg <= tx_gate_n ? txg_reg + {3'h0, txg_reg != 4'h8} : 4'h0;
    end
  end
  sequence rx_rise_s;
    $rose(rx_clock_pin);
  endsequence
  sequence rx_bit_s;
    ##[2:6] rx_bit_en;
  endsequence
  zero_wait_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
  osc_level_a: assert property (settled |-> osc_enable ==
    ((cfg_reg[2:0] == 3'h0 && cfg_reg[4]) || cfg_reg[2:1] == 2'h3))
    else $error("oscillator enable wrong");
  rts_route_a: assert property (settled |-> rts_clock_route ==
    (cfg_reg[2:0] == 3'h4 && cfg_reg[7])) else $error("rts clock route wrong");
  // rts copy trails the tx pin by two sync stages, the edge stage and its own flop
  rts_follow_a: assert property (rts_clock_o == $past(tx_clock_pin_i, 4))
    else $error("rts clock does not follow tx pin");
  mode0_drive_a: assert property (settled && cfg_reg[2:0] == 3'h0 |-> tx_clock_pin_oe ==
    (cfg_reg[4] && cfg_reg[6])) else $error("tx pin drive wrong in mode 0");
  rx_follow_a: assert property (settled && cfg_reg[2:0] == 3'h0 ##0 rx_rise_s |-> rx_bit_s)
    else $error("rx bit missing after rx pin rise");
  rx_gated_a: assert property (settled && cfg_reg[2:0] == 3'h4 &&
    rxg_reg == 4'h8 |-> !rx_bit_en) else $error("rx bit while gated");
  tx_gated_a: assert property (settled && cfg_reg[2:0] == 3'h4 &&
    txg_reg == 4'h8 |-> !tx_bit_en) else $error("tx bit while gated");
  bit_single_a: assert property (rx_bit_en || tx_bit_en |=> !$past(rx_bit_en) || !rx_bit_en)
    else $error("rx bit enable longer than one cycle");
  reset_state_a: assert property ($rose(presetn) |-> tx_clock_pin_o && !tx_clock_pin_oe
    && !rts_clock_route) else $error("outputs not at reset values");
endmodule
bind sccm_clock_modes sccm_clock_modes_monitor sccm_clock_modes_monitor_i (.*);

// file: sccm_clock_modes_tb_top.sv
// self-checking bench for the clock mode selector
`timescale 1ns/100ps
module sccm_clock_modes_tb_top;
  import sccm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tx_clock_pin_o, tx_clock_pin_oe, rts_clock_route, osc_enable;
  logic rx_bit_en, tx_bit_en, rx_clock_pin, tx_line, crystal_input, frame_sync_pin, tx_wire;
  logic carrier_detect_pin, rx_gate_n, tx_gate_n, rxp, txp, xp;
  logic run = 1'b0, rx_ok = 1'b1, tx_ok = 1'b1, strobe = 1'b0;
  int n_fail = 0, tests_run = 0;
  int cnt[6]; // rx bits, tx bits, tx bits with pin not driven low, rx/tx/crystal rises
  // cfg, rate, rx source, rx divide, tx source, tx divide
  int rows[10][6] = '{'{12'h000, 0, 3, 1, 4, 1}, '{12'h050, 12'h101, 3, 1, 5, 4},
    '{12'h001, 0, 3, 1, 3, 1}, '{12'h002, 0, 3, 16, 4, 1}, '{12'h012, 0, 3, 16, 3, 16},
    '{12'h003, 0, 3, 16, 3, 16}, '{12'h013, 0, 3, 1, 3, 1}, '{12'h006, 0, 5, 16, 4, 1},
    '{12'h016, 0, 5, 16, 5, 16}, '{12'h0a4, 0, 3, 1, 4, 1}};
  logic [31:0] wmask[6] = '{32'h3f7, 32'hf3f, 32'h01ff077f, 32'h01ff077f, 32'hffffffff,
    32'hffffffff};
  sccm_line_model sccm_line_model_i (.pclk, .run, .rx_permit(rx_ok), .tx_permit(tx_ok),
    .strobe_mode(strobe), .rx_clock_pin, .tx_line, .crystal_input, .frame_sync_pin,
    .carrier_detect_pin, .rx_gate_n, .tx_gate_n);
  // tx pin level: the design wins while it drives
  assign tx_wire = (tx_clock_pin_oe === 1'b1) ? tx_clock_pin_o : tx_line;
  sccm_clock_modes sccm_clock_modes_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_clock_pin, .tx_clock_pin_i(tx_wire),
    .tx_clock_pin_o, .tx_clock_pin_oe, .crystal_input, .carrier_detect_pin, .rx_gate_n,
    .tx_gate_n, .frame_sync_pin, .rts_clock_o(), .rts_clock_route, .osc_enable, .rx_bit_en,
    .tx_bit_en);
  initial forever #10 pclk = ~pclk;
  // tally bit enables and pin rises
  always @(posedge pclk) begin
    cnt[0] += rx_bit_en === 1'b1;
    cnt[1] += tx_bit_en === 1'b1;
    cnt[2] += tx_bit_en === 1'b1 && (tx_clock_pin_o !== 1'b0 || tx_clock_pin_oe !== 1'b1);
    cnt[3] += rx_clock_pin && !rxp;
    cnt[4] += tx_line && !txp;
    cnt[5] += crystal_input && !xp;
    {rxp, txp, xp} = {rx_clock_pin, tx_line, crystal_input};
  end
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // tolerance covers the divider phase at start and stop
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got, input int tol);
    tests_run++;
    if (tol == 0 ? got !== exp : (got + tol < exp || got > exp + tol)) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", nm, exp, got);
    end
  endtask
  // configure with clocks stopped, then run the line for cyc edges
  task automatic go(input logic [31:0] cfg, input int cyc);
    apb(1'b1, ADDR_CFG, cfg);
    strobe <= cfg[2:0] == 3'h1;
    @(negedge pclk);
    cnt = '{default: 0};
    @(posedge pclk);
    run <= 1'b1;
    repeat (cyc) @(posedge pclk);
    run <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    results();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (wmask[i]) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd, 0);
      apb(1'b1, 8'(i * 4), 32'hffffffff);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("register bits", wmask[i], rd, 0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err}, 0);
    chk("unmapped data", 32'h0, rd, 0);
    $display("register test done");
    foreach (rows[i]) begin
      apb(1'b1, ADDR_RATE, rows[i][1]);
      go(rows[i][0], 384);
      chk("rx bits", cnt[rows[i][2]] / rows[i][3], cnt[0], 1);
      chk("tx bits", cnt[rows[i][4]] / rows[i][5], cnt[1], 1);
      $display("mode row %0d done", i);
    end
    rx_ok <= 1'b0;
    tx_ok <= 1'b0;
    // third pass: byte alignment, one strobe spanning a single bit opens eight
    for (int g = 0; g < 3; g++) begin
      fork
        go(g ? (g == 2 ? 32'h101 : 32'h1) : 32'ha4, 384);
        if (g == 2) begin
          repeat (30) @(posedge pclk);
          {rx_ok, tx_ok} <= 2'b11;
          repeat (6) @(posedge pclk);
          {rx_ok, tx_ok} <= 2'b00;
        end
      join
      chk("gated rx bits", g == 2 ? 8 : 0, cnt[0], 0);
      chk("gated tx bits", g == 2 ? 8 : 0, cnt[1], 0);
    end
    $display("gating test done");
    rx_ok <= 1'b1;
    tx_ok <= 1'b1;
    apb(1'b1, ADDR_TX_SLOT, 32'h00030201);
    apb(1'b1, ADDR_RX_SLOT, 32'h0);
    apb(1'b1, ADDR_TX_MASK, 32'h5);
    apb(1'b1, ADDR_RX_MASK, 32'h2);
    for (int m = 0; m < 2; m++) begin
      go(m ? 32'h245 : 32'h45, 1152);
      chk("slot tx bits", m ? 48 : 12, cnt[1], 1);
      chk("slot rx bits", m ? 24 : 3, cnt[0], 1);
      chk("tx pin high in slot", 32'h0, cnt[2], 0);
    end
    $display("slot test done");
    results();
  end
endmodule

// file: sccm_line_model.sv
// line side model: clocks, strobes, gates and frame sync
`timescale 1ns/100ps
module sccm_line_model #(
  parameter int FRAME = 64
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic rx_permit,
  input wire logic tx_permit,
  input wire logic strobe_mode,
  output logic rx_clock_pin,
  output logic tx_line,
  output logic crystal_input,
  output logic frame_sync_pin,
  output logic carrier_detect_pin,
  output logic rx_gate_n,
  output logic tx_gate_n
);
  int cyc_reg = 0; // pclk count since clocks started, 0 = stopped
  // clocks stand still low between runs; three distinct rates
  always_ff @(posedge pclk) begin
    cyc_reg <= run ? cyc_reg + 1 : 0;
  end
  assign rx_clock_pin = (cyc_reg / 3) % 2 == 1;
  assign crystal_input = (cyc_reg / 2) % 2 == 1;
  assign frame_sync_pin = cyc_reg != 0 && (cyc_reg / 6) % FRAME == 0;
  assign tx_line = strobe_mode ? tx_permit : (cyc_reg / 4) % 2 == 1;
  assign carrier_detect_pin = rx_permit;
  assign rx_gate_n = !rx_permit;
  assign tx_gate_n = !tx_permit;
endmodule

// file: sccm_pkg.sv
// constants and types shared by the serial channel clock mode logic
package sccm_pkg;

  // clock modes selected by the 3-bit mode field
  typedef enum logic [2:0] {
    SCCM_MODE_0 = 3'b000,
    SCCM_MODE_1 = 3'b001,
    SCCM_MODE_2 = 3'b010,
    SCCM_MODE_3 = 3'b011,
    SCCM_MODE_4 = 3'b100,
    SCCM_MODE_5 = 3'b101,
    SCCM_MODE_6 = 3'b110,
    SCCM_MODE_7 = 3'b111
  } sccm_mode_t;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_TX_SLOT = 8'h08;
  localparam logic [7:0] ADDR_RX_SLOT = 8'h0c;
  localparam logic [7:0] ADDR_TX_MASK = 8'h10;
  localparam logic [7:0] ADDR_RX_MASK = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // channel_config_0 field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SSEL = 4;
  localparam int CFG_HS = 5;
  localparam int CFG_TOE = 6;
  localparam int CFG_TX_CLOCK_OUT_SELECT = 7;
  localparam int CFG_BYTE_ALIGN = 8;
  localparam int CFG_PCM_MASK_EN = 9;

  // rate register fields: divider k = (n+1) * 2^m
  localparam int RATE_N_LSB = 0;
  localparam int RATE_M_LSB = 8;

  // slot assign register fields
  localparam int SLOT_NUM_LSB = 0;
  localparam int SLOT_SHIFT_LSB = 8;
  localparam int SLOT_WIDTH_LSB = 16;

  // reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] RATE_RESET = 32'h0000_0000;
  localparam logic [31:0] SLOT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // fixed ratios and counts
  localparam logic [3:0] REF_DIV_LAST = 4'hf;
  localparam logic [2:0] CHAR_BITS_LAST = 3'h7;
  localparam int SLOT_BITS_LOG2 = 3;

endpackage

// file: sccm_slot.sv
// time-slot assigner for one direction, referenced to frame sync
`timescale 1ns/100ps
module sccm_slot
  import sccm_pkg::*;
#(
  parameter int SLOT_COUNT = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  sccm_slot_if.slot_assigner s
);

  // mask indexing needs exactly the 32 mask bits
  if (SLOT_COUNT != 32) begin : g_bad
    $error("sccm_slot: SLOT_COUNT must be 32");
  end

  logic [10:0] bit_cnt_reg;  // bits since frame sync
  logic [10:0] delay;        // first bit of the slot
  logic [10:0] idx;          // position of the next bit
  logic [10:0] off;          // next bit relative to slot start
  logic window_next;

  // start delay is 1 + number*8 + shift, 1 to 1024 bits
  assign delay = 11'd1 + {1'b0, s.slot_num, 3'b000} + {8'h00, s.clk_shift};
  assign idx = bit_cnt_reg + 11'd1;
  assign off = idx - delay;

  // bit counter, cleared by frame sync, saturates to avoid wrap on lost sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 11'h000;
    end else if (s.frame_start) begin
      bit_cnt_reg <= 11'h000;
    end else if (s.bit_tick && bit_cnt_reg != 11'h7ff) begin
      bit_cnt_reg <= idx;
    end
  end

  // window decode: one programmable slot, or masked 8-bit slots
  always_comb begin
    window_next = 1'b0;
    if (idx >= delay) begin
      if (s.mask_en) begin
        // width field ignored, fixed 8-bit slots
        window_next = (off[10:8] == 3'b000) && s.mask[off[7:SLOT_BITS_LOG2]];
      end else begin
        window_next = (off <= {2'b00, s.width_m1});
      end
    end
  end

  // registered window; ticks are at least two cycles apart so it is settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.window <= 1'b0;
    end else begin
      s.window <= window_next;
    end
  end

endmodule

// file: sccm_slot_if.sv
// carrier between the clock selector and one time-slot assigner
`timescale 1ns/100ps
interface sccm_slot_if;
  logic bit_tick;           // one pulse per common bit clock
  logic frame_start;        // frame sync edge seen
  logic [6:0] slot_num;     // slot number field
  logic [2:0] clk_shift;    // clock shift field
  logic [8:0] width_m1;     // slot width minus one
  logic [31:0] mask;        // pcm mask, one bit per 8-bit slot
  logic mask_en;            // pcm masks in use
  logic window;             // next bit lies in an active slot

  modport ctl (output bit_tick, frame_start, slot_num, clk_shift, width_m1, mask, mask_en,
               input window);
  modport slot_assigner (input bit_tick, frame_start, slot_num, clk_shift, width_m1, mask, mask_en,
               output window);
endinterface
